// *** design/cbi_bus_interface.sv ***
// Multiplexed 16-bit processor bus interface, arbitration and discretes.
// Assumes pins synchronous to clk and three-state wires resolved outside.
//
// What this block does
// (RQ1) Drive data, direction, space cycle-type lines
// (RQ2) Release shared outputs outside owned cycles
// (RQ3) Address valid at address strobe falling edge
// (RQ4) Address-ready low inserts address wait states
// (RQ5) Active-low data strobe in every cycle
// (RQ6) Data-ready low inserts data wait states
// (RQ7) Shared 16-line bus, line 0 MSB
// (RQ8) Drive access key; zero means privileged
// (RQ9) Drive address-state page group select
// (RQ10) Request low until bus cycle begins
// (RQ11) Start on grant, bus free, unlocked, or while holding own lock
// (RQ12) Grant high keeps all shared outputs released outside a cycle or held lock
// (RQ13) Busy low marks the bus cycle
// (RQ14) Busy rising edge samples fault inputs
// (RQ15) Monitor busy during foreign cycles too
// (RQ16) Lock mimics busy in unlocked cycles
// (RQ17) Lock held across read-modify-write sequences
// (RQ18) DMA enable cleared by reset, set by commands
// (RQ19) Self test sets power-up; command clears it
// (RQ20) Start-new flags next-cycle instruction start
// (RQ21) Trigger reset pulses on I/O 400B, at init
// (RQ22) Unrecoverable and major error outputs
// (RQ23) Parity error captured in fault bit 2
// (RQ24) Address phase first, then data phase
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
module cbi_bus_interface (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Information bus, line 0 is the most significant
    input wire logic [0:15] infoBusIn,
    output logic [0:15] infoBusOut,
    output logic infoBusOeN,
    // Cycle-type, strobes, key and state, one shared enable
    output logic dataNotInstr,
    output logic readNotWrite,
    output logic memNotIo,
    output logic address_strobe,
    output logic data_strobe_n,
    output logic [3:0] access_key,
    output logic [3:0] address_state,
    output logic ctrlOeN,
    // Ready inputs
    input wire logic address_ready,
    input wire logic data_ready,
    // Arbitration
    output logic busReqN,
    input wire logic busGrantN,
    input wire logic busBusyIn,
    output logic busBusyOut,
    output logic busBusyOeN,
    input wire logic busLockIn,
    output logic busLockOut,
    output logic busLockOeN,
    // Fault inputs
    input wire logic protect_error_in_n,
    input wire logic parity_error_in_n,
    // Discretes
    output logic dmaEnable,
    output logic normal_powerup_out,
    output logic instr_start_next,
    output logic trigger_go_reset_n,
    output logic unrecoverable_error_out,
    output logic major_error_out
);

    ////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        cbi_pkg::cbi_state_type st; // Sequencer state
        logic isData; // Cycle is data access
        logic isRead; // Cycle reads
        logic isMem; // Cycle is memory
        logic lockReq; // Cycle keeps the lock
        logic [3:0] key; // Access key
        logic [3:0] aState; // Page group select
        logic [15:0] addr; // Cycle address
        logic [15:0] wdata; // Write data
        logic [15:0] rdata; // Last read data
        logic lockHeld; // Lock kept past cycle end
        logic ownCyc; // Current busy is ours
        logic prevBusy; // Busy wire, last cycle
        logic [15:0] fault; // Fault register
        logic dmaEn; // DMA enable discrete
        logic npu; // Normal power-up
        logic startNew; // Start-new pulse
        logic errU; // Unrecoverable error
        logic errM; // Major error
        logic [3:0] trigCnt; // Trigger pulse counter
        logic [31:0] rd; // APB read data
    } cbi_regs_type;

    cbi_regs_type r;
    cbi_regs_type next_r;

    // Decoded APB strobes, bus monitor events and fault set
    logic setup;
    logic wrEn;
    logic mapped;
    logic busEdge;
    logic acquire;
    logic [15:0] faultSet;

    ////////////////////////////////////////////////////////////
    // APB decode

    // Setup phase latches read data so prdata is a flop
    assign setup = psel && !penable;
    // Writes take effect at the single access edge
    assign wrEn = psel && penable && pwrite;
    // Registers fill the aligned words up to the last one
    assign mapped = paddr[1:0] == 2'h0 && paddr <= cbi_pkg::OFS_DISC;
    // Zero wait states: ready in every access phase
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign prdata = r.rd;

    ////////////////////////////////////////////////////////////
    // Bus monitoring

    // Busy trailing edge, seen on the wire whoever drives it
    assign busEdge = !r.prevBusy && busBusyIn; // [RQ14] [RQ15]
    // Free, unlocked bus with our grant, or our own lock
    assign acquire = r.lockHeld ||
                     (!busGrantN && busBusyIn && busLockIn); // [RQ11]

    // Fault bits caught at the busy trailing edge
    always_comb begin
        faultSet = 16'h0000;
        if (busEdge) begin
            faultSet[cbi_pkg::FLT_PROT_OWN] = !protect_error_in_n && r.ownCyc;
            faultSet[cbi_pkg::FLT_PROT_FOREIGN] = !protect_error_in_n && !r.ownCyc;
            faultSet[cbi_pkg::FLT_PARITY] = !parity_error_in_n; // [RQ23]
        end
    end

    ////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_r = r;
        next_r.prevBusy = busBusyIn;
        next_r.startNew = 1'b0;
        // Trailing edge ends ownership; a start at that edge sets it again
        if (busEdge) begin
            next_r.ownCyc = 1'b0;
        end
        // Trigger counter runs down to idle
        if (r.trigCnt != 4'h0) begin
            next_r.trigCnt = r.trigCnt - 4'h1;
        end

        // Bus cycle sequencer
        case (r.st)
            cbi_pkg::ST_IDLE: begin
                // Launch is taken in the APB block below
                next_r.st = cbi_pkg::ST_IDLE;
            end
            cbi_pkg::ST_REQ: begin
                if (acquire) begin
                    next_r.st = cbi_pkg::ST_ADDR; // [RQ11]
                    next_r.ownCyc = 1'b1;
                end
            end
            cbi_pkg::ST_ADDR: begin
                // Wait states stretch the address phase
                if (address_ready) begin // [RQ4]
                    next_r.st = cbi_pkg::ST_ALAT;
                end
            end
            cbi_pkg::ST_ALAT: begin
                // Address held one cycle past strobe fall
                next_r.st = cbi_pkg::ST_DATA; // [RQ3] [RQ24]
            end
            cbi_pkg::ST_DATA: begin
                // Wait states stretch the data phase
                if (data_ready) begin // [RQ6]
                    next_r.st = cbi_pkg::ST_END;
                    if (r.isRead) begin
                        next_r.rdata = infoBusIn;
                    end
                    // Program-controlled trigger pulse
                    if (!r.isMem && !r.isRead &&
                        r.addr == cbi_pkg::IO_TRIG_ADDR) begin
                        next_r.trigCnt = cbi_pkg::TRIG_PULSE_CYC; // [RQ21]
                    end
                end
            end
            cbi_pkg::ST_END: begin
                // Lock survives only when this cycle asked for it
                next_r.st = cbi_pkg::ST_IDLE;
                next_r.lockHeld = r.lockReq; // [RQ17]
            end
            default: begin
                next_r.st = cbi_pkg::ST_IDLE;
            end
        endcase

        // Set wins over software clear
        if (wrEn && paddr == cbi_pkg::OFS_FAULT) begin
            next_r.fault = r.fault & ~pwdata[15:0];
        end
        next_r.fault = next_r.fault | faultSet; // [RQ14]

        // Register writes
        if (wrEn) begin
            case (paddr)
                cbi_pkg::OFS_CTRL: begin
                    // Ignored while a cycle is pending
                    if (r.st == cbi_pkg::ST_IDLE) begin
                        next_r.isData = pwdata[cbi_pkg::CTRL_DATA];
                        next_r.isRead = pwdata[cbi_pkg::CTRL_READ];
                        next_r.isMem = pwdata[cbi_pkg::CTRL_MEM];
                        next_r.lockReq = pwdata[cbi_pkg::CTRL_LOCK];
                        next_r.key = pwdata[cbi_pkg::CTRL_KEY +: 4];
                        next_r.aState = pwdata[cbi_pkg::CTRL_ASTATE +: 4];
                        next_r.st = cbi_pkg::ST_REQ; // [RQ10]
                    end
                end
                cbi_pkg::OFS_ADDR: begin
                    next_r.addr = pwdata[15:0];
                end
                cbi_pkg::OFS_WDATA: begin
                    next_r.wdata = pwdata[15:0];
                end
                cbi_pkg::OFS_DISC: begin
                    // Enable wins when both commands come at once
                    if (pwdata[cbi_pkg::DISC_DMA_OFF]) begin
                        next_r.dmaEn = 1'b0;
                    end
                    if (pwdata[cbi_pkg::DISC_DMA_ON]) begin
                        next_r.dmaEn = 1'b1; // [RQ18]
                    end
                    if (pwdata[cbi_pkg::DISC_PWR_CLR]) begin
                        next_r.npu = 1'b0;
                    end
                    if (pwdata[cbi_pkg::DISC_BIST]) begin
                        next_r.npu = 1'b1; // [RQ19]
                    end
                    next_r.startNew = pwdata[cbi_pkg::DISC_START]; // [RQ20]
                    next_r.errU = pwdata[cbi_pkg::DISC_FATAL]; // [RQ22]
                    next_r.errM = pwdata[cbi_pkg::DISC_MAJOR]; // [RQ22]
                end
                default: next_r.addr = next_r.addr;
            endcase
        end

        // Read data is captured in the setup phase
        if (setup) begin
            case (paddr)
                cbi_pkg::OFS_CTRL: begin
                    next_r.rd = {20'h00000, r.aState, r.key, r.lockReq,
                                 r.isMem, r.isRead, r.isData};
                end
                cbi_pkg::OFS_ADDR: next_r.rd = {16'h0000, r.addr};
                cbi_pkg::OFS_WDATA: next_r.rd = {16'h0000, r.wdata};
                cbi_pkg::OFS_RDATA: next_r.rd = {16'h0000, r.rdata};
                cbi_pkg::OFS_STATUS: begin
                    next_r.rd = {28'h0000000,
                                 r.st != cbi_pkg::ST_IDLE && r.st != cbi_pkg::ST_REQ,
                                 r.key == 4'h0, // [RQ8]
                                 r.lockHeld,
                                 r.st != cbi_pkg::ST_IDLE};
                end
                cbi_pkg::OFS_FAULT: next_r.rd = {16'h0000, r.fault};
                cbi_pkg::OFS_DISC: begin
                    next_r.rd = {25'h0000000, r.errM, r.errU, 2'b00,
                                 r.npu, 1'b0, r.dmaEn};
                end
                default: next_r.rd = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // Registers

    // Reset clears DMA and starts the init trigger pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
            r.st <= cbi_pkg::ST_IDLE;
            r.prevBusy <= 1'b1;
            r.fault <= cbi_pkg::FAULT_RESET;
            r.dmaEn <= 1'b0; // [RQ18]
            r.trigCnt <= cbi_pkg::INIT_PULSE_CYC; // [RQ21]
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////
    // Pin drive

    logic inCycle;
    logic own;
    // Busy is driven from address phase to the end cycle
    assign inCycle = r.st == cbi_pkg::ST_ADDR || r.st == cbi_pkg::ST_ALAT ||
                     r.st == cbi_pkg::ST_DATA || r.st == cbi_pkg::ST_END;
    // Grant high outside a cycle or lock leaves us released
    assign own = inCycle || r.lockHeld; // [RQ2] [RQ12]

    assign ctrlOeN = !own; // [RQ2]
    assign dataNotInstr = r.isData; // [RQ1]
    assign readNotWrite = r.isRead; // [RQ1]
    assign memNotIo = r.isMem; // [RQ1]
    assign access_key = r.key; // [RQ8]
    assign address_state = r.aState; // [RQ9]
    assign address_strobe = r.st == cbi_pkg::ST_ADDR; // [RQ3]
    assign data_strobe_n = r.st != cbi_pkg::ST_DATA; // [RQ5]
    // Address first, then write data; read leaves the bus
    assign infoBusOut = (r.st == cbi_pkg::ST_DATA) ? r.wdata : r.addr; // [RQ7] [RQ24]
    assign infoBusOeN = !(r.st == cbi_pkg::ST_ADDR || r.st == cbi_pkg::ST_ALAT ||
                          (r.st == cbi_pkg::ST_DATA && !r.isRead));
    assign busReqN = r.st != cbi_pkg::ST_REQ; // [RQ10]
    assign busBusyOut = r.st == cbi_pkg::ST_END; // [RQ13]
    assign busBusyOeN = !inCycle;
    // Lock copies busy unless the lock is being kept
    assign busLockOut = busBusyOut && !r.lockReq; // [RQ16]
    assign busLockOeN = !own;
    assign dmaEnable = r.dmaEn;
    assign normal_powerup_out = r.npu;
    assign instr_start_next = r.startNew;
    assign trigger_go_reset_n = r.trigCnt == 4'h0;
    assign unrecoverable_error_out = r.errU;
    assign major_error_out = r.errM;

    ////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_release_idle: assert property ( // [RQ2] [RQ12]
        r.st == cbi_pkg::ST_IDLE && !r.lockHeld |-> ctrlOeN && infoBusOeN && busBusyOeN)
        else $error("shared outputs driven while not owned");

    chk_cycle_types: assert property ( // [RQ1]
        address_strobe |-> !ctrlOeN && readNotWrite == r.isRead && memNotIo == r.isMem)
        else $error("cycle-type lines wrong in address phase");

    chk_req_release: assert property ( // [RQ10]
        r.st == cbi_pkg::ST_REQ && acquire |=> busReqN && address_strobe && !busBusyOut)
        else $error("request not released at cycle start");

    chk_addr_wait: assert property ( // [RQ4]
        address_strobe && !address_ready |=> address_strobe && data_strobe_n)
        else $error("address phase not extended");

    chk_addr_hold: assert property ( // [RQ3]
        $fell(address_strobe) |-> !infoBusOeN && infoBusOut == $past(infoBusOut) ##1 !data_strobe_n)
        else $error("address not held at strobe fall");

    chk_data_wait: assert property ( // [RQ6]
        !data_strobe_n && !data_ready |=> !data_strobe_n && !busBusyOut)
        else $error("data phase not extended");

    chk_parity_bit: assert property ( // [RQ23]
        !r.prevBusy && busBusyIn && !parity_error_in_n |=> r.fault[cbi_pkg::FLT_PARITY])
        else $error("parity fault not captured");

    chk_lock_mimic: assert property ( // [RQ16]
        !busBusyOeN && !r.lockReq && !r.lockHeld |-> busLockOut == busBusyOut)
        else $error("lock does not follow busy");

    chk_trig_io: assert property ( // [RQ21]
        r.st == cbi_pkg::ST_DATA && data_ready && !r.isMem && !r.isRead &&
        r.addr == cbi_pkg::IO_TRIG_ADDR |=> !trigger_go_reset_n [*4] ##1 trigger_go_reset_n)
        else $error("trigger pulse wrong after I/O write");

    chk_dma_cmd: assert property ( // [RQ18]
        wrEn && paddr == cbi_pkg::OFS_DISC && pwdata[cbi_pkg::DISC_DMA_ON] |=> dmaEnable)
        else $error("DMA enable command lost");

endmodule

// *** inc/cbi_pkg.sv ***
// Constants and types of the multiplexed bus interface.
// Assumes one 250 MHz clock and an APB register port.
package cbi_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_RDATA = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_FAULT = 8'h14;
    localparam logic [7:0] OFS_DISC = 8'h18;
    // Control register fields
    localparam int CTRL_DATA = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_MEM = 2;
    localparam int CTRL_LOCK = 3;
    localparam int CTRL_KEY = 4;
    localparam int CTRL_ASTATE = 8;
    // Status register fields
    localparam int STAT_PEND = 0;
    localparam int STAT_LOCK = 1;
    localparam int STAT_PRIV = 2;
    localparam int STAT_OWN = 3;
    // Discrete register fields
    localparam int DISC_DMA_ON = 0;
    localparam int DISC_DMA_OFF = 1;
    localparam int DISC_PWR_CLR = 2;
    localparam int DISC_BIST = 3;
    localparam int DISC_START = 4;
    localparam int DISC_FATAL = 5;
    localparam int DISC_MAJOR = 6;
    // Fault register fields
    localparam int FLT_PROT_OWN = 0;
    localparam int FLT_PROT_FOREIGN = 1;
    localparam int FLT_PARITY = 2;
    // Fixed values
    localparam logic [15:0] IO_TRIG_ADDR = 16'h400B;
    localparam logic [3:0] TRIG_PULSE_CYC = 4'h4;
    localparam logic [3:0] INIT_PULSE_CYC = 4'h8;
    localparam logic [15:0] FAULT_RESET = 16'h0000;
    // Bus cycle sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ = 3'b001,
        ST_ADDR = 3'b010,
        ST_ALAT = 3'b011,
        ST_DATA = 3'b100,
        ST_END = 3'b101
    } cbi_state_type;
endpackage

// *** tb/cbi_partner_model.sv ***
// Far-side model: arbiter, memory and I/O device with wait states.
// Assumes the bench resolves the shared wires and picks stall counts.
`timescale 1ns/1ps
module cbi_partner_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bench controls
    input wire logic grantHold,
    input wire logic [1:0] waitA,
    input wire logic [1:0] waitD,
    input wire logic [15:0] readWord,
    // Resolved device pins
    input wire logic busReqN,
    input wire logic ownN,
    input wire logic address_strobe,
    input wire logic data_strobe_n,
    input wire logic readNotWrite,
    input wire logic [0:15] infoBusIn,
    // Answers
    output logic busGrantN,
    output logic address_ready,
    output logic data_ready,
    output logic [15:0] farDrive,
    output logic [15:0] capAddr,
    output logic [15:0] capData
);
    logic [1:0] cntA; // Address wait states so far
    logic [1:0] cntD; // Data wait states so far
    logic strobeD; // Strobe one edge ago
    logic [15:0] lastDrive; // Last value put on the bus
    ////////////////////////////////
    // Grant kept through an owned cycle
    assign busGrantN = grantHold | (busReqN & ownN);
    // Ready withheld for the chosen number of wait states
    assign address_ready = address_strobe & (cntA == waitA);
    assign data_ready = !data_strobe_n & (cntD == waitD);
    // Released bus shows the inverse of its last value
    assign farDrive = (!data_strobe_n && readNotWrite) ? readWord : ~lastDrive;
    // Counters and capture of address and write data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cntA <= 2'h0;
            cntD <= 2'h0;
            strobeD <= 1'h0;
            lastDrive <= 16'h0000;
            capAddr <= 16'h0000;
            capData <= 16'h0000;
        end else begin
            cntA <= address_strobe ? cntA + 2'h1 : 2'h0;
            cntD <= !data_strobe_n ? cntD + 2'h1 : 2'h0;
            strobeD <= address_strobe;
            lastDrive <= farDrive;
            // Address taken as the strobe falls
            if (strobeD && !address_strobe) begin
                capAddr <= infoBusIn;
            end
            if (data_ready && !readNotWrite) begin
                capData <= infoBusIn;
            end
        end
    end
endmodule

// *** tb/cbi_bus_interface_tb_top.sv ***
// Bench: APB master, far-side model and reference checks.
// Assumes one 250 MHz clock and wires resolved here from the enables.
`timescale 1ns/1ps
module cbi_bus_interface_tb_top;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv, r, seed;
    logic [0:15] infoBusIn, infoBusOut;
    logic infoBusOeN, dataNotInstr, readNotWrite, memNotIo, address_strobe, data_strobe_n, ctrlOeN;
    logic [3:0] access_key, address_state;
    logic address_ready, data_ready, busReqN, busGrantN, busBusyIn, busBusyOut, busBusyOeN;
    logic busLockIn, busLockOut, busLockOeN, protect_error_in_n, parity_error_in_n;
    logic dmaEnable, normal_powerup_out, instr_start_next, trigger_go_reset_n;
    logic unrecoverable_error_out, major_error_out, grantHold, foreignBusyN, errv, dma, pwr;
    logic [1:0] waitA, waitD;
    logic [15:0] readWord, farDrive, capAddr, capData;
    int nErrors, checkCount, cycles, k, n;
    ////////////////////////////////
    // Wire resolution; busy and lock have pull-ups
    assign infoBusIn = infoBusOeN ? farDrive : infoBusOut;
    assign busBusyIn = (busBusyOeN | busBusyOut) & foreignBusyN;
    assign busLockIn = busLockOeN | busLockOut;
    cbi_bus_interface cbi_bus_interface_inst (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .infoBusIn, .infoBusOut, .infoBusOeN, .dataNotInstr, .readNotWrite,
        .memNotIo, .address_strobe, .data_strobe_n, .access_key, .address_state, .ctrlOeN, .address_ready,
        .data_ready, .busReqN, .busGrantN, .busBusyIn, .busBusyOut, .busBusyOeN, .busLockIn, .busLockOut,
        .busLockOeN, .protect_error_in_n, .parity_error_in_n, .dmaEnable, .normal_powerup_out,
        .instr_start_next, .trigger_go_reset_n, .unrecoverable_error_out, .major_error_out);
    cbi_partner_model cbi_partner_model_inst (.clk, .sys_rst, .grantHold, .waitA, .waitD, .readWord,
        .busReqN, .ownN(busBusyOeN & busLockOeN), .address_strobe(address_strobe & !ctrlOeN),
        .data_strobe_n(data_strobe_n | ctrlOeN), .readNotWrite(readNotWrite & !ctrlOeN), .infoBusIn,
        .busGrantN, .address_ready, .data_ready, .farDrive, .capAddr, .capData);
    // Free-running clock
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // Hang guard, far above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            nErrors++;
            finalReport();
        end
    end
    ////////////////////////////////
    task finalReport();
        if (nErrors == 0 && checkCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task tick();
        @(posedge clk);
        #1;
    endtask
    // One APB transfer; answer taken at the edge that sees pready high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // One bus cycle with random stalls, watched at the pins
    task run(input logic [11:0] ctl, input logic [15:0] a, input logic hold);
        logic [15:0] wd, rw;
        int na, nd, nt, post, i, wa, wb;
        wd = 16'(xs());
        rw = 16'(xs());
        wa = int'(xs() % 4);
        wb = int'(xs() % 4);
        waitA <= 2'(wa);
        waitD <= 2'(wb);
        readWord <= rw;
        grantHold <= hold;
        apb(1'h1, cbi_pkg::OFS_ADDR, {16'h0000, a});
        apb(1'h1, cbi_pkg::OFS_WDATA, {16'h0000, wd});
        apb(1'h1, cbi_pkg::OFS_CTRL, {20'h00000, ctl});
        if (hold) begin
            repeat (6) begin
                tick();
                check({busReqN, ctrlOeN, infoBusOeN}, 3'h3);
            end
            @(posedge clk);
            grantHold <= 1'h0;
        end
        na = 0;
        nd = 0;
        nt = 0;
        post = 0;
        i = 0;
        while (post < 8 && i < 60) begin
            tick();
            i++;
            nt += !trigger_go_reset_n;
            post += (nd > 0 && data_strobe_n);
            if (!ctrlOeN && address_strobe) begin
                na++;
                check(infoBusOut, a);
                check({dataNotInstr, readNotWrite, memNotIo}, {ctl[0], ctl[1], ctl[2]});
                check({access_key, address_state}, {ctl[7:4], ctl[11:8]});
                check({busReqN, infoBusOeN, busBusyIn}, 3'h4);
            end
            if (!ctrlOeN && !data_strobe_n) begin
                nd++;
                check({address_strobe, infoBusOeN}, {1'h0, ctl[1]});
                if (!ctl[1]) check(infoBusOut, wd);
            end
            if (!busBusyOeN && !ctl[3]) check(busLockOut, busBusyOut);
            if (ctrlOeN) check({infoBusOeN, busBusyOeN}, 2'h3);
        end
        check(na, wa + 1);
        check(nd, wb + 1);
        check(capAddr, a);
        check(nt, (!ctl[1] && !ctl[2] && a == cbi_pkg::IO_TRIG_ADDR) ? cbi_pkg::TRIG_PULSE_CYC : 4'h0);
        if (ctl[1]) begin
            apb(1'h0, cbi_pkg::OFS_RDATA, 32'h0);
            check(rdv, rw);
        end else begin
            check(capData, wd);
        end
        apb(1'h0, cbi_pkg::OFS_STATUS, 32'h0);
        check(rdv & 32'h7, {ctl[7:4] == 4'h0, ctl[3], 1'h0});
    endtask
    ////////////////////////////////
    initial begin
        seed = 32'h00000005;
        {sys_rst, protect_error_in_n, parity_error_in_n, foreignBusyN} = 4'hF;
        {psel, penable, pwrite, grantHold, waitA, waitD} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        readWord = 16'h0000;
        {dma, pwr} = 2'h0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        #1;
        n = 0;
        repeat (12) begin
            n += !trigger_go_reset_n;
            tick();
        end
        check({dmaEnable, normal_powerup_out, ctrlOeN, infoBusOeN, busBusyOeN, busLockOeN}, 6'hF);
        check(n, cbi_pkg::INIT_PULSE_CYC);
        // Every cycle type, the first six at the trigger address
        for (k = 0; k < 8; k++) begin
            r = xs();
            run({r[11:8], (k == 0) ? 4'h0 : r[7:4], 1'h0, 3'(k)}, (k < 6) ? cbi_pkg::IO_TRIG_ADDR : r[31:16], k == 3);
        end
        // Locked cycle, then an unlocked cycle that ends the lock
        run(12'h007 | 12'h008, 16'h1234, 1'h0);
        check({busLockOeN, busLockIn}, 2'h0);
        run(12'h315, 16'hBEEF, 1'h0);
        check(busLockOeN, 1'h1);
        // Faults during an own cycle, then during a foreign one
        @(posedge clk);
        {protect_error_in_n, parity_error_in_n} <= 2'h0;
        run(12'h105, 16'h0042, 1'h0);
        @(posedge clk);
        {protect_error_in_n, parity_error_in_n} <= 2'h3;
        apb(1'h0, cbi_pkg::OFS_FAULT, 32'h0);
        check(rdv, 32'h5);
        apb(1'h1, cbi_pkg::OFS_FAULT, 32'h7);
        apb(1'h0, cbi_pkg::OFS_FAULT, 32'h0);
        check(rdv, 32'h0);
        @(posedge clk);
        {foreignBusyN, protect_error_in_n} <= 2'h0;
        repeat (3) begin
            tick();
            check({ctrlOeN, busBusyOeN}, 2'h3);
        end
        @(posedge clk);
        foreignBusyN <= 1'h1;
        repeat (2) @(posedge clk);
        protect_error_in_n <= 1'h1;
        apb(1'h0, cbi_pkg::OFS_FAULT, 32'h0);
        check(rdv, 32'h2);
        // Discrete commands against the reference model
        for (k = 0; k < 14; k++) begin
            r = xs() & 32'h7F;
            apb(1'h1, cbi_pkg::OFS_DISC, r);
            if (r[0]) dma = 1'h1;
            else if (r[1]) dma = 1'h0;
            if (r[3]) pwr = 1'h1;
            else if (r[2]) pwr = 1'h0;
            #1;
            n = instr_start_next;
            repeat (3) begin
                tick();
                n += instr_start_next;
            end
            check(n, r[4]);
            check({dmaEnable, normal_powerup_out, unrecoverable_error_out, major_error_out},
                {dma, pwr, r[5], r[6]});
            apb(1'h0, cbi_pkg::OFS_DISC, 32'h0);
            check(rdv, {r[6], r[5], 2'h0, pwr, 1'h0, dma});
        end
        // Unmapped place is refused
        apb(1'h0, 8'h1C, 32'h0);
        check({errv, rdv[15:0]}, 17'h10000);
        finalReport();
    end
endmodule
